/* File: logic/tmh_pkg.sv */
// Purpose: Constants for the three-channel 8-bit PWM / carrier timer
// Assumes: Single 10 MHz clock, plain register port, 8-bit data
// Notes:   Offsets are register indices on a 4-bit address

package tmh_pkg;

    localparam int unsigned NUM_CH      = 3;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned NUM_SEL     = 8;
    localparam int unsigned CARRIER_CH  = 1;

    // Per-channel register indices, channel c at c*4 + offset
    localparam logic [1:0] OFF_MODE     = 2'h0;
    localparam logic [1:0] OFF_PERIOD   = 2'h1;
    localparam logic [1:0] OFF_DUTY     = 2'h2;
    localparam logic [1:0] OFF_COUNT    = 2'h3;

    // Shared registers
    localparam logic [3:0] ADDR_STATUS  = 4'hC;
    localparam logic [3:0] ADDR_MASK    = 4'hD;
    localparam logic [3:0] ADDR_LIVE    = 4'hE;

    // Mode register fields
    localparam int unsigned MODE_EN_BIT  = 7;
    localparam int unsigned MODE_SEL_LSB = 4;
    localparam int unsigned MODE_CAR_BIT = 3;
    localparam int unsigned MODE_ACT_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_PERIOD   = 8'hFF;
    localparam logic [7:0] RST_DUTY     = 8'h00;
    localparam logic       RST_ACT_HI   = 1'b1;
    localparam logic [2:0] RST_MASK     = 3'h0;

    // Count clocks before a new duty value may be used
    localparam logic [1:0] DUTY_XFER_CLOCKS = 2'h3;

    // 10 MHz reference, period in ns
    localparam int unsigned REF_CLK_NS  = 100;

endpackage : tmh_pkg

/* File: logic/tmh_prescaler.sv */
// Purpose: Divider giving one-cycle count enables at ref/2^k
// Assumes: One clock, asynchronous active-high reset
// Notes:   Tick 0 is high every cycle
`timescale 1ns/1ps

module tmh_prescaler #(
    parameter int unsigned SEL_N = tmh_pkg::NUM_SEL
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    output logic [SEL_N-1:0]      tick
);

    typedef struct packed {
        logic [SEL_N-1:0] div;
        logic [SEL_N-1:0] tick;
    } tmh_div_t;

    tmh_div_t s_reg;
    tmh_div_t s_next;

    // Below two taps nothing divides
    if (SEL_N < 2 || SEL_N > 16)
    begin : g_bad_sel
        $error("tmh_prescaler: SEL_N out of range");
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.div = s_reg.div + {{(SEL_N-1){1'b0}}, 1'b1};
        s_next.tick[0] = 1'b1;
        for (int k = 1; k < SEL_N; k++)
        begin
            // All low bits set: the next increment rolls stage k
            s_next.tick[k] = &(s_reg.div | ~((SEL_N'(1) << k) - SEL_N'(1)));
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule : tmh_prescaler

/* File: logic/tmh_timer.sv */
// Purpose: Three 8-bit timer channels with PWM mode; carrier mode on channel 1 only
// Assumes: Inputs synchronous to ref_clk; master never waits
// Notes:   Read data valid the cycle after the read strobe
`timescale 1ns/1ps

module tmh_timer (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic [tmh_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [tmh_pkg::DATA_W-1:0]  bus_wdata,
    input  wire logic                        bus_wr,
    input  wire logic                        bus_rd,
    output logic [tmh_pkg::DATA_W-1:0]       bus_rdata,
    output logic [1:0]                       timer_pwm_output,
    output logic                             event_enable_out,
    output logic                             compare_match_irq
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [2:0]       en;
        logic [2:0][2:0]  sel;
        logic             carrier;
        logic [2:0]       act_hi;
        logic [2:0][7:0]  period;
        logic [2:0][7:0]  duty_sh;
        logic [2:0][7:0]  duty_act;
        logic [2:0]       pend;
        logic [2:0][1:0]  dly;
        logic [2:0][7:0]  cnt;
        logic [2:0]       phase;
        logic [2:0]       lvl;
        logic [2:0]       sts;
        logic [2:0]       msk;
        logic [7:0]       rdata;
        logic [1:0]       pin;
        logic             evt_en;
        logic             irq;
    } tmh_state_t;

    tmh_state_t s_reg;
    tmh_state_t s_next;

    logic [tmh_pkg::NUM_SEL-1:0] tick;
    logic [2:0]                  ev;
    logic                        car;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] ch_addr(input int c,
                                           input logic [1:0] off);
        logic [3:0] a;
        a = {2'(c), off};
        return a;
    endfunction : ch_addr

    function automatic logic [7:0] mode_byte(input logic en,
                                             input logic [2:0] sel,
                                             input logic car_md,
                                             input logic act);
        logic [7:0] b;
        b = 8'h00;
        b[tmh_pkg::MODE_EN_BIT] = en;
        b[tmh_pkg::MODE_SEL_LSB +: 3] = sel;
        b[tmh_pkg::MODE_CAR_BIT] = car_md;
        b[tmh_pkg::MODE_ACT_BIT] = act;
        return b;
    endfunction : mode_byte

    // Pending duty value may move once its delay has run out
    function automatic logic xfer_ready(input logic pend,
                                        input logic [1:0] dly);
        logic r;
        r = pend && (dly == tmh_pkg::DUTY_XFER_CLOCKS);
        return r;
    endfunction : xfer_ready

    // Wraps at 8 bits; a skipped match costs a full lap
    function automatic logic [7:0] count_up(input logic [7:0] v);
        logic [7:0] r;
        r = v + 8'h01;
        return r;
    endfunction : count_up

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // State layout is written for three 8-bit channels
    if (tmh_pkg::NUM_CH != 3 || tmh_pkg::DATA_W != 8)
    begin : g_bad_width
        $error("tmh_timer: channel count or width unsupported");
    end

    // A 3-bit clock select reaches up to tick 7
    if (tmh_pkg::NUM_SEL < 8)
    begin : g_bad_sel
        $error("tmh_timer: too few prescaler taps");
    end

    // Four registers per channel behind a 4-bit index
    if (tmh_pkg::ADDR_W != 4 ||
        tmh_pkg::CARRIER_CH >= tmh_pkg::NUM_CH)
    begin : g_bad_map
        $error("tmh_timer: register map unsupported");
    end

    // Mode fields must fit the byte
    if (tmh_pkg::MODE_EN_BIT > 7 || tmh_pkg::MODE_SEL_LSB > 5 ||
        tmh_pkg::MODE_CAR_BIT > 7 || tmh_pkg::MODE_ACT_BIT > 7)
    begin : g_bad_mode
        $error("tmh_timer: mode field outside byte");
    end

    ////////////////////////////////////////////////////////////////////
    // Count clock divider

    tmh_prescaler #(
        .SEL_N (tmh_pkg::NUM_SEL)
    ) u_prescaler (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_next = s_reg;
        ev = 3'h0;
        car = 1'b0;
        s_next.rdata = 8'h00;

        // Channel engines
        for (int c = 0; c < 3; c++)
        begin
            car = (c == tmh_pkg::CARRIER_CH) && s_reg.carrier;
            if (!s_reg.en[c])
            begin
                // Hold idle; start is clean from count 0 and default
                s_next.cnt[c] = 8'h00;
                s_next.phase[c] = 1'b0;
                s_next.lvl[c] = 1'b0;
                s_next.dly[c] = 2'h0;
                if (s_reg.pend[c])
                begin
                    s_next.duty_act[c] = s_reg.duty_sh[c];
                    s_next.pend[c] = 1'b0;
                end
            end
            else if (tick[s_reg.sel[c]])
            begin
                if (s_reg.pend[c] &&
                    s_reg.dly[c] != tmh_pkg::DUTY_XFER_CLOCKS)
                begin
                    s_next.dly[c] = s_reg.dly[c] + 2'h1;
                end
                if (!s_reg.phase[c])
                begin
                    if (s_reg.cnt[c] == s_reg.period[c])
                    begin
                        s_next.cnt[c] = 8'h00;
                        ev[c] = 1'b1;
                        s_next.lvl[c] = car ? ~s_reg.lvl[c] : 1'b1;
                        s_next.phase[c] = 1'b1;
                    end
                    else
                    begin
                        s_next.cnt[c] = count_up(s_reg.cnt[c]);
                    end
                end
                else if (s_reg.cnt[c] == s_reg.duty_act[c])
                begin
                    if (car)
                    begin
                        s_next.cnt[c] = 8'h00;
                        ev[c] = 1'b1;
                        s_next.lvl[c] = ~s_reg.lvl[c];
                        s_next.phase[c] = 1'b0;
                        // Match used the old value; swap after it
                        if (xfer_ready(s_reg.pend[c], s_reg.dly[c]))
                        begin
                            s_next.duty_act[c] = s_reg.duty_sh[c];
                            s_next.pend[c] = 1'b0;
                        end
                    end
                    else
                    begin
                        s_next.lvl[c] = 1'b0;
                        s_next.phase[c] = 1'b0;
                        s_next.cnt[c] = count_up(s_reg.cnt[c]);
                        // Duty equal to period: full-on pulse
                        if (s_reg.cnt[c] == s_reg.period[c])
                        begin
                            s_next.cnt[c] = 8'h00;
                            ev[c] = 1'b1;
                            s_next.lvl[c] = 1'b1;
                            s_next.phase[c] = 1'b1;
                        end
                    end
                end
                else
                begin
                    s_next.cnt[c] = count_up(s_reg.cnt[c]);
                end
                // Swap while comparing the period, or before the
                // count has passed the new value: else a lap is lost
                if (!car && xfer_ready(s_reg.pend[c], s_next.dly[c]) &&
                    (!s_next.phase[c] ||
                     s_next.cnt[c] <= s_reg.duty_sh[c]))
                begin
                    s_next.duty_act[c] = s_reg.duty_sh[c];
                    s_next.pend[c] = 1'b0;
                end
            end
        end

        // Register writes
        if (bus_wr)
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_MODE))
                begin
                    s_next.en[c] = bus_wdata[tmh_pkg::MODE_EN_BIT];
                    s_next.sel[c] = bus_wdata[tmh_pkg::MODE_SEL_LSB +: 3];
                    s_next.act_hi[c] = bus_wdata[tmh_pkg::MODE_ACT_BIT];
                    if (c == tmh_pkg::CARRIER_CH)
                    begin
                        s_next.carrier = bus_wdata[tmh_pkg::MODE_CAR_BIT];
                    end
                end
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_PERIOD))
                begin
                    // Rewrite while running is not guarded
                    s_next.period[c] = bus_wdata;
                end
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_DUTY))
                begin
                    s_next.duty_sh[c] = bus_wdata;
                    if (s_reg.en[c])
                    begin
                        s_next.pend[c] = 1'b1;
                        s_next.dly[c] = 2'h0;
                    end
                    else
                    begin
                        s_next.duty_act[c] = bus_wdata;
                        s_next.pend[c] = 1'b0;
                    end
                end
            end
            if (bus_addr == tmh_pkg::ADDR_MASK)
            begin
                s_next.msk = bus_wdata[2:0];
            end
        end

        // Sticky events, cleared by a status read; set wins
        if (bus_rd && bus_addr == tmh_pkg::ADDR_STATUS)
        begin
            s_next.sts = ev;
        end
        else
        begin
            s_next.sts = s_reg.sts | ev;
        end

        // Register reads
        if (bus_rd)
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_MODE))
                begin
                    s_next.rdata = mode_byte(s_reg.en[c], s_reg.sel[c],
                        (c == tmh_pkg::CARRIER_CH) && s_reg.carrier,
                        s_reg.act_hi[c]);
                end
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_PERIOD))
                begin
                    s_next.rdata = s_reg.period[c];
                end
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_DUTY))
                begin
                    s_next.rdata = s_reg.duty_sh[c];
                end
                if (bus_addr == ch_addr(c, tmh_pkg::OFF_COUNT))
                begin
                    s_next.rdata = s_reg.cnt[c];
                end
            end
            if (bus_addr == tmh_pkg::ADDR_STATUS)
            begin
                s_next.rdata = {5'h00, s_reg.sts};
            end
            if (bus_addr == tmh_pkg::ADDR_MASK)
            begin
                s_next.rdata = {5'h00, s_reg.msk};
            end
            if (bus_addr == tmh_pkg::ADDR_LIVE)
            begin
                s_next.rdata = {1'b0, s_reg.phase, 1'b0, s_reg.lvl};
            end
        end

        // Registered outputs; channel 2 has no pin
        for (int c = 0; c < 2; c++)
        begin
            s_next.pin[c] = s_next.lvl[c] ~^ s_next.act_hi[c];
        end
        s_next.evt_en = s_next.lvl[2];
        s_next.irq = |(s_next.sts & s_next.msk);
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.act_hi <= {3{tmh_pkg::RST_ACT_HI}};
            s_reg.period <= {3{tmh_pkg::RST_PERIOD}};
            s_reg.duty_sh <= {3{tmh_pkg::RST_DUTY}};
            s_reg.duty_act <= {3{tmh_pkg::RST_DUTY}};
            s_reg.msk <= tmh_pkg::RST_MASK;
            s_reg.pin <= {2{~tmh_pkg::RST_ACT_HI}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata = s_reg.rdata;
    assign timer_pwm_output = s_reg.pin;
    assign event_enable_out = s_reg.evt_en;
    assign compare_match_irq = s_reg.irq;

endmodule : tmh_timer

/* File: sim/test_tmh_timer.sv */
// Purpose: Self-checking bench of the PWM / carrier timer
// Assumes: 10 MHz clock, pin loads on all three outputs
// Notes:   Reads queue their expected data for the monitor
`timescale 1ns/1ps

module test_tmh_timer;
    logic             ref_clk = 1'b0;
    logic             rst = 1'b1;
    logic [3:0]       bus_addr = 4'h0;
    logic [7:0]       bus_wdata = 8'h00;
    logic             bus_wr = 1'b0;
    logic             bus_rd = 1'b0;
    logic [7:0]       bus_rdata;
    logic [1:0]       timer_pwm_output;
    logic             event_enable_out;
    logic             compare_match_irq;
    logic [2:0]       pins;
    logic [2:0][15:0] hi_len;
    logic [2:0][15:0] per_len;
    logic [7:0]       exp_q[$];
    logic             rd_seen = 1'b0;
    logic [31:0]      seed = 32'h0001_08D9;
    logic [7:0]       n_val;
    logic [7:0]       m_val;
    int               n_errors = 0;
    int               comparisons = 0;
    int               cycles = 0;

    assign pins = {event_enable_out, timer_pwm_output};
    always #50 ref_clk = ~ref_clk;

    tmh_timer dut (
        .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .timer_pwm_output(timer_pwm_output),
        .event_enable_out(event_enable_out),
        .compare_match_irq(compare_match_irq)
    );

    for (genvar i = 0; i < 3; i++)
    begin : g_load
        tmh_pin_load u_load (
            .ref_clk(ref_clk), .rst(rst), .sig(pins[i]),
            .hi_len(hi_len[i]), .per_len(per_len[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    function logic [7:0] rnd(input logic [7:0] span);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return 8'(seed % 32'(span));
    endfunction : rnd

    task check(input string name, input logic [15:0] seen,
               input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Settle past the edge so registered outputs have landed
    task idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        exp_q.push_back(d);
        @(posedge ref_clk);
        bus_rd <= 1'b0;
    endtask : rd

    task pwm_check(input logic [3:0] base, input int ch,
                   input logic [7:0] n, input logic [7:0] m);
        wr(base + 4'h1, n);
        wr(base + 4'h2, m);
        wr(base, 8'h82);
        idle(3 * n + 12);
        check("hi_len", hi_len[ch], 16'(m) + 16'h0001);
        check("per_len", per_len[ch], 16'(n) + 16'h0001);
    endtask : pwm_check

    ////////////////////////////////////////////////////////////////////////
    // Read data stand one cycle after the strobe only
    always @(posedge ref_clk)
    begin
        if (rd_seen)
            check("bus_rdata", 16'(bus_rdata), 16'(exp_q.pop_front()));
        rd_seen <= bus_rd;
    end

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(4'h1, 8'hFF);
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h00);
        rd(tmh_pkg::ADDR_STATUS, 8'h00);
        rd(4'hF, 8'h00);
        n_val = rnd(8'h08) + 8'h03;
        m_val = rnd(n_val);
        pwm_check(4'h0, 0, n_val, m_val);
        rd(tmh_pkg::ADDR_STATUS, 8'h01);
        check("irq", 16'(compare_match_irq), 16'h0000);
        wr(tmh_pkg::ADDR_MASK, 8'h01);
        rd(tmh_pkg::ADDR_MASK, 8'h01);
        idle(12);
        check("irq", 16'(compare_match_irq), 16'h0001);
        m_val = rnd(n_val);
        wr(4'h2, m_val);
        rd(4'h2, m_val);
        idle(3 * n_val + 12);
        check("hi_len", hi_len[0], 16'(m_val) + 16'h0001);
        wr(4'h0, 8'h02);
        rd(4'h3, 8'h00);
        rd(tmh_pkg::ADDR_STATUS, 8'h01);
        idle(2);
        check("irq", 16'(compare_match_irq), 16'h0000);
        check("pin0", 16'(timer_pwm_output[0]), 16'h0000);
        rd(tmh_pkg::ADDR_STATUS, 8'h00);
        // Slow count clock, active-low pin
        m_val = rnd(n_val);
        wr(4'h2, m_val);
        wr(4'h0, 8'h90);
        idle(6 * n_val + 24);
        check("hi_len", hi_len[0], 16'(n_val - m_val) * 16'h0002);
        check("per_len", per_len[0], 16'(n_val) * 16'h0002 + 16'h0002);
        wr(4'h0, 8'h10);
        rd(tmh_pkg::ADDR_STATUS, 8'h01);
        rd(4'h0, 8'h10);
        // Carrier mode, pin 1
        n_val = rnd(8'h06) + 8'h02;
        m_val = rnd(8'h06) + 8'h01;
        wr(4'h5, n_val);
        wr(4'h6, m_val);
        wr(4'h4, 8'h8A);
        idle(1);
        check("pin1", 16'(timer_pwm_output[1]), 16'h0000);
        idle(3 * (n_val + m_val) + 14);
        check("hi_len", hi_len[1], 16'(m_val) + 16'h0001);
        check("per_len", per_len[1], 16'(n_val + m_val) + 16'h0002);
        rd(tmh_pkg::ADDR_STATUS, 8'h02);
        m_val = rnd(8'h06) + 8'h01;
        wr(4'h6, m_val);
        idle(4 * (n_val + m_val) + 20);
        check("hi_len", hi_len[1], 16'(m_val) + 16'h0001);
        wr(4'h4, 8'h02);
        pwm_check(4'h8, 2, 8'h04, rnd(8'h04));
        wr(4'h8, 8'h02);
        rd(tmh_pkg::ADDR_STATUS, 8'h06);
        rd(tmh_pkg::ADDR_LIVE, 8'h00);
        idle(3);
        tally_and_finish();
    end
endmodule : test_tmh_timer

/* File: sim/tmh_pin_load.sv */
// Purpose: Pin load measuring pulse width and period
// Assumes: Level input sampled on ref_clk
// Notes:   Results hold until the next full pulse
`timescale 1ns/1ps

module tmh_pin_load (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    input  wire logic   sig,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    logic        prev_reg;
    logic [15:0] cyc_reg;
    logic [15:0] hcnt_reg;

    // Rise starts a cycle; fall closes the pulse
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prev_reg <= 1'b0;
            cyc_reg  <= 16'h0000;
            hcnt_reg <= 16'h0000;
            hi_len   <= 16'h0000;
            per_len  <= 16'h0000;
        end
        else
        begin
            prev_reg <= sig;
            cyc_reg  <= (sig && !prev_reg) ? 16'h0001 : cyc_reg + 16'h0001;
            hcnt_reg <= sig ? hcnt_reg + 16'h0001 : 16'h0000;
            if (sig && !prev_reg)
                per_len <= cyc_reg;
            if (!sig && prev_reg)
                hi_len <= hcnt_reg;
        end
    end
endmodule : tmh_pin_load

/* File: sim/tmh_timer_chk.sv */
// Purpose: Port-level checks of the PWM / carrier timer
// Assumes: One clock, register map of tmh_pkg
// Notes:   Helper copies track enable and mask writes
`timescale 1ns/1ps

module tmh_timer_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [1:0] timer_pwm_output,
    input wire logic       event_enable_out,
    input wire logic       compare_match_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic       en0_reg;
    logic [2:0] mask_reg;

    ////////////////////////////////////////////////////////////////////////
    // Copies of software state, taken from the bus only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            en0_reg  <= 1'b0;
            mask_reg <= 3'h0;
        end
        else if (bus_wr)
        begin
            if (bus_addr == 4'h0)
                en0_reg <= bus_wdata[7];
            if (bus_addr == tmh_pkg::ADDR_MASK)
                mask_reg <= bus_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_DUTY_RDBK: assert property (
        (bus_wr && bus_addr == 4'h2) ##1 !bus_wr ##1
        (bus_rd && bus_addr == 4'h2) |=> bus_rdata == $past(bus_wdata, 3))
        else $error("duty readback differs");
    AST_MASK_RDBK: assert property (
        (bus_wr && bus_addr == tmh_pkg::ADDR_MASK) ##1 !bus_wr ##1
        (bus_rd && bus_addr == tmh_pkg::ADDR_MASK)
        |=> bus_rdata == {5'h00, $past(bus_wdata[2:0], 3)})
        else $error("mask readback differs");
    AST_IRQ_MASKED: assert property (
        (mask_reg == 3'h0 && $past(mask_reg) == 3'h0) |-> !compare_match_irq)
        else $error("irq high with all sources masked");
    AST_PIN0_OFF: assert property (
        (bus_wr && bus_addr == 4'h0 && !bus_wdata[7])
        ##1 !(bus_wr && bus_addr == 4'h0)
        |=> timer_pwm_output[0] == !$past(bus_wdata[1], 2))
        else $error("pin 0 not inactive after stop");
    AST_PIN1_OFF: assert property (
        (bus_wr && bus_addr == 4'h4 && !bus_wdata[7])
        ##1 !(bus_wr && bus_addr == 4'h4)
        |=> timer_pwm_output[1] == !$past(bus_wdata[1], 2))
        else $error("pin 1 not inactive after stop");
    AST_EVENT_OFF: assert property (
        (bus_wr && bus_addr == 4'h8 && !bus_wdata[7])
        ##1 !(bus_wr && bus_addr == 4'h8) |=> !event_enable_out)
        else $error("event enable not off after stop");
    AST_COUNT_ZERO: assert property (
        (bus_rd && bus_addr == 4'h3 && !en0_reg && !$past(en0_reg))
        |=> bus_rdata == 8'h00)
        else $error("stopped counter not zero");
    AST_STATUS_W: assert property (
        (bus_rd && bus_addr == tmh_pkg::ADDR_STATUS)
        |=> bus_rdata[7:3] == 5'h00)
        else $error("status beyond three channels");
endmodule : tmh_timer_chk

bind tmh_timer tmh_timer_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .timer_pwm_output(timer_pwm_output),
    .event_enable_out(event_enable_out),
    .compare_match_irq(compare_match_irq)
);
